// ---- fsa_pkg.sv ----
// fsa_pkg: offsets, bit positions, reset values and carrier types for the fault/status bank
// assumes a register access port that delivers decoded word-wide writes and reads
package fsa_pkg;
	localparam logic [7:0] GEN_STATUS_OFFSET = 8'h10;
	localparam logic [7:0] LINK_ERR_OFFSET = 8'h11;
	localparam int REG_WIDTH = 13;
	localparam int LED_COUNT = 12;
	localparam int GEN_THERM_WARN_BIT = 0;
	localparam int GEN_THERM_SHDN_BIT = 1;
	localparam int GEN_PUMP_BIT = 2;
	localparam int GEN_SHORT_BIT = 3;
	localparam int GEN_OPEN_BIT = 4;
	localparam int GEN_LINK_ERR_BIT = 6;
	localparam int GEN_EXT_CLK_BIT = 7;
	localparam int GEN_RES_DECODE_BIT = 8;
	localparam int GEN_CFG_BUSY_BIT = 9;
	localparam int GEN_OTP_CRC_BIT = 10;
	localparam int LINK_PL_START_BIT = 1;
	localparam int LINK_PL_STOP_BIT = 2;
	localparam int LINK_SYNC_STOP_BIT = 3;
	localparam int LINK_PL_PARITY_BIT = 4;
	localparam int LINK_SYNC_PARITY_BIT = 5;
	localparam int LINK_CRC_BIT = 6;
	localparam int LINK_TIMEOUT_BIT = 7;
	localparam int LINK_WATCHDOG_BIT = 8;
	localparam logic [12:0] STATUS_RESET = 13'h0000;
	localparam logic [12:0] LINK_ERR_MASK = 13'h01FE;
	localparam logic [12:0] GEN_W1C_MASK = 13'h0003;
	// mask bit positions inside the fault-mask configuration word
	localparam int MSK_THERM_WARN_BIT = 0;
	localparam int MSK_RES_DECODE_BIT = 1;
	localparam int MSK_PUMP_BIT = 2;
	localparam int MSK_SHORT_BIT = 3;
	localparam int MSK_OPEN_BIT = 4;
	localparam int MSK_LINK_ERR_BIT = 6;
	localparam logic [1:0] CLK_SEL_EXT_LSB = 2'h2;

	typedef struct packed {
		logic therm_warn;
		logic therm_shdn;
		logic pump_not_ready;
		logic ext_clock_too_slow;
		logic resistor_decode_pending;
		logic config_busy;
		logic otp_crc_mismatch;
	} fsa_chip_events_t;

	typedef struct packed {
		logic idle_watchdog;
		logic rx_timeout;
		logic crc_error;
		logic sync_frame_parity_error;
		logic payload_parity_error;
		logic sync_stop_error;
		logic payload_stop_error;
		logic payload_start_error;
	} fsa_link_events_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [7:0] addr;
		logic [12:0] wdata;
	} fsa_reg_req_t;
endpackage

// ---- fsa_status_bank.sv ----
// fsa_status_bank: general status and serial-link error registers plus active-low fault pin
// assumes the serial-link front end decodes frames into register requests and pulses events
// What this block does
// - fault pin asserted by any unmasked fault bit
// - bit 10 flags otp crc mismatch, no fault
// - bit 9 shows configuration busy, no fault
// - bit 8 high until resistor decode done
// - bit 7 external clock too slow
// - bit 6 is OR of link errors
// - bit 4 is OR of open flags
// - bit 3 is OR of short flags
// - bit 2 live pump-not-ready, unlatched
// - bit 1 latches thermal shutdown, w1c
// - bit 0 latches thermal warning, w1c
// - link bit 8 sets on idle watchdog
// - link bit 7 sets on rx timeout
// - link bit 6 sets on crc reject
// - link bit 5 sync frame parity error
// - link bit 4 payload parity error
// - link bit 3 sync frame stop error
// - link bit 2 payload stop error
// - link bit 1 payload start error
// - mask bit 1 keeps source off fault pin
// - per-led mask keeps that led's faults off the fault pin only
`timescale 1ns/1ps
module fsa_status_bank import fsa_pkg::*; #(
	parameter int LEDS = LED_COUNT
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register access
	input wire fsa_reg_req_t reg_req,
	output logic [12:0] reg_rdata,
	output logic reg_rvalid,
	// device event sources
	input wire fsa_chip_events_t chip_events,
	input wire logic [1:0] pwm_clock_select,
	input wire fsa_link_events_t link_events,
	input wire logic [LEDS-1:0] per_led_open_flags,
	input wire logic [LEDS-1:0] per_led_short_flags,
	// configuration from neighbouring registers
	input wire logic [12:0] fault_mask_config,
	input wire logic [LEDS-1:0] per_led_fault_mask,
	// status outputs
	output logic fault_pin_n,
	output logic timeout_switch_action
);
	// per-led gating and the 12-bit summaries are sized for one count only
	generate
		if (LEDS != LED_COUNT) begin : g_bad_leds
			$error("fsa_status_bank supports only the documented LED count");
		end
	endgenerate

	// register access decode
	logic gen_write;
	logic link_write;
	logic gen_read;
	logic link_read;
	logic [12:0] write_ones;

	assign gen_write = reg_req.wr_en && (reg_req.addr == GEN_STATUS_OFFSET);
	assign link_write = reg_req.wr_en && (reg_req.addr == LINK_ERR_OFFSET);
	assign gen_read = reg_req.rd_en && (reg_req.addr == GEN_STATUS_OFFSET);
	assign link_read = reg_req.rd_en && (reg_req.addr == LINK_ERR_OFFSET);
	assign write_ones = reg_req.wdata;

	// per-led gating before summarising for the pin
	logic [LEDS-1:0] open_pass;
	logic [LEDS-1:0] short_pass;

	genvar gi;
	generate
		for (gi = 0; gi < LEDS; gi++) begin : g_led
			assign open_pass[gi] = per_led_open_flags[gi] & ~per_led_fault_mask[gi];
			assign short_pass[gi] = per_led_short_flags[gi] & ~per_led_fault_mask[gi];
		end
	endgenerate

	// summaries report every led; only the pin path honours the led mask
	logic open_summary;
	logic short_summary;
	logic open_unmasked;
	logic short_unmasked;

	assign open_summary = |per_led_open_flags;
	assign short_summary = |per_led_short_flags;
	assign open_unmasked = |open_pass;
	assign short_unmasked = |short_pass;

	// only selects with the upper bit set route the external clock
	logic ext_clock_selected;
	logic external_clock_too_slow;

	assign ext_clock_selected = pwm_clock_select[1] == CLK_SEL_EXT_LSB[1];
	assign external_clock_too_slow = chip_events.ext_clock_too_slow && ext_clock_selected;

	// thermal warning: a clearing write loses against a new event
	logic therm_warn_reg;
	logic therm_warn_next;
	logic warn_clear;

	assign warn_clear = gen_write && write_ones[GEN_THERM_WARN_BIT];

	always_comb begin
		therm_warn_next = therm_warn_reg;
		if (warn_clear) begin
			therm_warn_next = 1'b0;
		end
		if (chip_events.therm_warn) begin
			therm_warn_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			therm_warn_reg <= 1'b0;
		end else begin
			therm_warn_reg <= therm_warn_next;
		end
	end

	// thermal shutdown: same set-wins policy as the warning flag
	logic therm_shdn_reg;
	logic therm_shdn_next;
	logic shdn_clear;

	assign shdn_clear = gen_write && write_ones[GEN_THERM_SHDN_BIT];

	always_comb begin
		therm_shdn_next = therm_shdn_reg;
		if (shdn_clear) begin
			therm_shdn_next = 1'b0;
		end
		if (chip_events.therm_shdn) begin
			therm_shdn_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			therm_shdn_reg <= 1'b0;
		end else begin
			therm_shdn_reg <= therm_shdn_next;
		end
	end

	// link error events placed at their register bit positions
	logic [12:0] link_err_reg;
	logic [12:0] link_err_set;
	logic [12:0] link_err_clr;
	logic [12:0] link_err_next;

	always_comb begin
		link_err_set = STATUS_RESET;
		link_err_set[LINK_PL_START_BIT] = link_events.payload_start_error;
		link_err_set[LINK_PL_STOP_BIT] = link_events.payload_stop_error;
		link_err_set[LINK_SYNC_STOP_BIT] = link_events.sync_stop_error;
		link_err_set[LINK_PL_PARITY_BIT] = link_events.payload_parity_error;
		link_err_set[LINK_SYNC_PARITY_BIT] = link_events.sync_frame_parity_error;
		link_err_set[LINK_CRC_BIT] = link_events.crc_error;
		link_err_set[LINK_TIMEOUT_BIT] = link_events.rx_timeout;
		link_err_set[LINK_WATCHDOG_BIT] = link_events.idle_watchdog;
	end

	// ones written outside the error field are ignored
	assign link_err_clr = link_write ? (write_ones & LINK_ERR_MASK) : STATUS_RESET;

	// one latch per bit; unused positions are held at zero
	genvar bi;
	generate
		for (bi = 0; bi < REG_WIDTH; bi++) begin : g_link_bit
			if (LINK_ERR_MASK[bi]) begin : g_used
				assign link_err_next[bi] = link_err_set[bi] | (link_err_reg[bi] & ~link_err_clr[bi]);
			end else begin : g_unused
				assign link_err_next[bi] = 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			link_err_reg <= STATUS_RESET;
		end else begin
			link_err_reg <= link_err_next;
		end
	end

	logic link_any;

	assign link_any = |link_err_reg;

	// general status assembly; bit 5 and 11-12 read zero
	logic [12:0] general_status;

	always_comb begin
		general_status = STATUS_RESET;
		general_status[GEN_THERM_WARN_BIT] = therm_warn_reg;
		general_status[GEN_THERM_SHDN_BIT] = therm_shdn_reg;
		general_status[GEN_PUMP_BIT] = chip_events.pump_not_ready;
		general_status[GEN_SHORT_BIT] = short_summary;
		general_status[GEN_OPEN_BIT] = open_summary;
		general_status[GEN_LINK_ERR_BIT] = link_any;
		general_status[GEN_EXT_CLK_BIT] = external_clock_too_slow;
		general_status[GEN_RES_DECODE_BIT] = chip_events.resistor_decode_pending;
		general_status[GEN_CFG_BUSY_BIT] = chip_events.config_busy;
		general_status[GEN_OTP_CRC_BIT] = chip_events.otp_crc_mismatch;
	end

	// each source except shutdown and slow clock qualified by its own mask bit before the pin or
	logic warn_to_pin;
	logic decode_to_pin;
	logic pump_to_pin;
	logic short_to_pin;
	logic open_to_pin;
	logic link_to_pin;
	logic shdn_to_pin;
	logic clock_to_pin;
	logic fault_next;

	assign warn_to_pin = therm_warn_reg && !fault_mask_config[MSK_THERM_WARN_BIT];
	assign decode_to_pin = chip_events.resistor_decode_pending &&
		!fault_mask_config[MSK_RES_DECODE_BIT];
	assign pump_to_pin = chip_events.pump_not_ready && !fault_mask_config[MSK_PUMP_BIT];
	assign short_to_pin = short_unmasked && !fault_mask_config[MSK_SHORT_BIT];
	assign open_to_pin = open_unmasked && !fault_mask_config[MSK_OPEN_BIT];
	assign link_to_pin = link_any && !fault_mask_config[MSK_LINK_ERR_BIT];
	// shutdown and slow clock have no mask bit, so they always reach the pin
	assign shdn_to_pin = therm_shdn_reg;
	assign clock_to_pin = external_clock_too_slow;

	// otp crc and config busy deliberately left out
	always_comb begin
		fault_next = 1'b0;
		if (warn_to_pin || decode_to_pin || pump_to_pin || short_to_pin) begin
			fault_next = 1'b1;
		end
		if (open_to_pin || link_to_pin || shdn_to_pin || clock_to_pin) begin
			fault_next = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			fault_pin_n <= 1'b1;
		end else begin
			fault_pin_n <= ~fault_next;
		end
	end

	// timeout flag tells the switch logic to take its watchdog state
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			timeout_switch_action <= 1'b0;
		end else begin
			timeout_switch_action <= link_err_next[LINK_TIMEOUT_BIT];
		end
	end

	// read selection; unmapped reads return zero
	logic [12:0] read_word;

	always_comb begin
		read_word = STATUS_RESET;
		if (gen_read) begin
			read_word = general_status;
		end else if (link_read) begin
			read_word = link_err_reg;
		end
	end

	// answer valid for one cycle after the request
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_req.rd_en;
		end
	end

	// data holds between reads so a slow host can pick it up late
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			reg_rdata <= STATUS_RESET;
		end else if (reg_req.rd_en) begin
			reg_rdata <= read_word;
		end
	end
endmodule

// ---- fsa_status_bank_properties.sv ----
// checker: port timing of the status bank
// assumes it is bound to each fsa_status_bank
`timescale 1ns/1ps
module fsa_props import fsa_pkg::*; #(parameter int LEDS = 12) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register port
	input wire fsa_reg_req_t reg_req,
	input wire logic [12:0] reg_rdata,
	input wire logic reg_rvalid,
	// sources
	input wire fsa_chip_events_t chip_events,
	input wire logic [1:0] pwm_clock_select,
	input wire fsa_link_events_t link_events,
	input wire logic [LEDS-1:0] per_led_short_flags,
	input wire logic [12:0] fault_mask_config,
	// outputs
	input wire logic fault_pin_n,
	input wire logic timeout_switch_action
);
	wire rd10 = reg_req.rd_en && reg_req.addr == GEN_STATUS_OFFSET;
	wire rd11 = reg_req.rd_en && reg_req.addr == LINK_ERR_OFFSET;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	AST_RESET: assert property (disable iff (1'b0) reset |=> fault_pin_n && !reg_rvalid)
		else $error("outputs live in reset");
	AST_LINK_RSVD: assert property (rd11 |=> reg_rvalid && reg_rdata[12:9] == 0 && !reg_rdata[0])
		else $error("link read bad");
	AST_CRC_SET: assert property (link_events.crc_error ##1 !reg_req.wr_en
		##1 (rd11 && !reg_req.wr_en) |=> reg_rdata[LINK_CRC_BIT]) else $error("crc lost");
	AST_TIMEOUT: assert property (link_events.rx_timeout |=> timeout_switch_action)
		else $error("no switch action");
	AST_EXT_CLK: assert property (chip_events.ext_clock_too_slow && pwm_clock_select[1]
		|=> !fault_pin_n) else $error("clock fault missed");
	AST_PUMP: assert property (chip_events.pump_not_ready && !fault_mask_config[2]
		|=> !fault_pin_n) else $error("pump fault missed");
	AST_SHORT_SUM: assert property (rd10 && $stable(per_led_short_flags)
		|=> reg_rdata[3] == |$past(per_led_short_flags)) else $error("short sum bad");
	AST_WARN_CLR: assert property ((reg_req.wr_en && reg_req.wdata[0] && !chip_events.therm_warn
		&& reg_req.addr == GEN_STATUS_OFFSET) ##1 !(reg_req.wr_en || chip_events.therm_warn)
		##1 (rd10 && !chip_events.therm_warn) |=> !reg_rdata[0]) else $error("warn kept");
	cover property (rd11 ##1 reg_rdata[LINK_CRC_BIT]);
	cover property (!fault_pin_n ##1 fault_pin_n);
	cover property (timeout_switch_action);
endmodule
bind fsa_status_bank fsa_props #(.LEDS(LEDS)) u_props (.sys_clk(sys_clk), .reset(reset),
	.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
	.chip_events(chip_events), .pwm_clock_select(pwm_clock_select),
	.link_events(link_events), .per_led_short_flags(per_led_short_flags),
	.fault_mask_config(fault_mask_config), .fault_pin_n(fault_pin_n),
	.timeout_switch_action(timeout_switch_action));

// ---- fsa_host_model.sv ----
// host model: register reads and writes
// assumes calls start at a falling edge
`timescale 1ns/1ps
module fsa_host import fsa_pkg::*; (
	// clock
	input wire logic sys_clk,
	// register port
	output fsa_reg_req_t reg_req,
	input wire logic [12:0] reg_rdata
);
	initial reg_req = '0;
	task automatic wr(input logic [7:0] a, input logic [12:0] v);
		@(negedge sys_clk) reg_req = '{1'b1, 1'b0, a, v};
		@(negedge sys_clk) reg_req = '0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [12:0] v);
		@(negedge sys_clk) reg_req = '{1'b0, 1'b1, a, 13'h0000};
		@(negedge sys_clk) reg_req = '0;
		v = reg_rdata;
	endtask
	// bounded so a stuck busy bit cannot hang the host
	task automatic wait_idle(output logic ok);
		logic [12:0] v;
		ok = 1'b0;
		for (int i = 0; i < 20 && !ok; i++) begin
			rd(GEN_STATUS_OFFSET, v);
			ok = !v[GEN_CFG_BUSY_BIT];
		end
	endtask
endmodule

// ---- fsa_status_bank_bench.sv ----
// bench: corner and random stimulus for the status bank
// assumes fsa_host drives requests and fsa_props is bound
`timescale 1ns/1ps
module fsa_status_bank_bench import fsa_pkg::*;;
	logic sys_clk = 1'b0, reset = 1'b1, rv, pin_n, tsa, ok;
	fsa_reg_req_t req;
	logic [12:0] rdata, d, mask = '0;
	fsa_chip_events_t ce = '0;
	fsa_link_events_t le = '0;
	logic [1:0] sel = '0;
	logic [11:0] op = '0, sh = '0, lm = '0;
	int bad_count = 0, samples_checked = 0, cyc = 0, seed = 49;
	fsa_status_bank uut (.sys_clk(sys_clk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
		.reg_rvalid(rv), .chip_events(ce), .pwm_clock_select(sel), .link_events(le),
		.per_led_open_flags(op), .per_led_short_flags(sh), .fault_mask_config(mask),
		.per_led_fault_mask(lm), .fault_pin_n(pin_n), .timeout_switch_action(tsa));
	fsa_host host (.sys_clk(sys_clk), .reg_req(req), .reg_rdata(rdata));
	initial forever #5 sys_clk = ~sys_clk;
	task automatic chk(input string n, input logic [12:0] e, input logic [12:0] s);
		samples_checked++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic final_report;
		if (bad_count == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	function automatic logic [12:0] gen_exp();
		return {3'b000, ce.config_busy, ce.resistor_decode_pending,
			ce.ext_clock_too_slow & sel[1], 2'b00, |op, |sh, ce.pump_not_ready, 2'b00} |
			{2'b00, ce.otp_crc_mismatch, 10'h000};
	endfunction
	function automatic logic pin_exp();
		return !((ce.pump_not_ready & !mask[2]) | (ce.resistor_decode_pending & !mask[1]) |
			(ce.ext_clock_too_slow & sel[1]) | (|(op & ~lm) & !mask[4]) | (|(sh & ~lm) & !mask[3]));
	endfunction
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk) reset = 1'b0;
		host.rd(8'h3C, d);
		chk("unmapped", 13'h0000, d);
		for (int i = 1; i <= 9; i++) begin
			fork
				host.wr(i < 9 ? LINK_ERR_OFFSET : GEN_STATUS_OFFSET, 13'h0000);
				begin
					@(negedge sys_clk) {ce.therm_warn, ce.therm_shdn, le} = 10'(1 << (i - 1));
					@(negedge sys_clk) {ce.therm_warn, ce.therm_shdn, le} = '0;
				end
			join
			host.rd(i < 9 ? LINK_ERR_OFFSET : GEN_STATUS_OFFSET, d);
			chk("set", i < 9 ? 13'(1 << i) : 13'h0002, d);
			chk("pin", 13'h0000, 13'(pin_n));
			host.wr(i < 9 ? LINK_ERR_OFFSET : GEN_STATUS_OFFSET, i < 9 ? 13'(1 << i) : 13'h0002);
			host.rd(GEN_STATUS_OFFSET, d);
			chk("clear", 13'h0000, d);
		end
		fork
			host.wr(GEN_STATUS_OFFSET, 13'h0001);
			@(negedge sys_clk) ce.therm_warn = 1'b1;
		join
		ce.therm_warn = 1'b0;
		host.rd(GEN_STATUS_OFFSET, d);
		chk("warn", 13'h0001, d);
		host.wr(GEN_STATUS_OFFSET, 13'h0001);
		for (int k = 0; k < 40; k++) begin
			@(negedge sys_clk);
			{ce[4:0], sel, mask} = 20'($random(seed));
			{op, sh, lm} = 36'({$random(seed), $random(seed)});
			if (k % 4 == 0)
				lm = op | sh;
			host.rd(GEN_STATUS_OFFSET, d);
			chk("gen", gen_exp(), d);
			chk("pin", 13'(pin_exp()), 13'(pin_n));
		end
		ce.config_busy = 1'b0;
		host.wait_idle(ok);
		chk("idle", 13'h0001, 13'(ok));
		final_report();
	end
endmodule
